// *** logic/timer_pkg.sv ***
package timer_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_LOW = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_HIGH = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_ENABLES = 8'h20;

  localparam int unsigned BIT_TIMER_ON = 0;
  localparam int unsigned BIT_CLOCK_SOURCE = 1;
  localparam int unsigned BIT_SYNC_CONTROL = 2;
  localparam int unsigned BIT_CRYSTAL_ENABLE = 3;
  localparam int unsigned BIT_PRESCALE_LO = 4;
  localparam int unsigned BIT_PRESCALE_HI = 5;
  localparam int unsigned BIT_OVERFLOW = 0;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'h3f;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;

  localparam int unsigned INSTR_DIV = 4;
  localparam int unsigned PRESCALE_W = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Prescale mask: 2**select - 1, so select 0 passes every edge.
  function automatic logic [PRESCALE_W-1:0] prescale_mask(input logic [1:0] sel);
    prescale_mask = PRESCALE_W'((1 << sel) - 1);
  endfunction : prescale_mask

endpackage : timer_pkg

// *** logic/pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int unsigned W = 2
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      dout <= '0;
    end else if (clk_en) begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule : pin_sync
`default_nettype wire

// *** logic/ripple_prescaler.sv ***
`timescale 1ns/10ps
`default_nettype none
module ripple_prescaler #(
  parameter int unsigned W = timer_pkg::PRESCALE_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic clear,
  input wire logic edge_in,
  input wire logic [1:0] select,
  output logic tick
);

  logic [W-1:0] count_q;
  logic [W-1:0] mask;

  // Each stage toggles when all lower stages are set, as a ripple chain would.
  always_comb begin
    mask = timer_pkg::prescale_mask(select);
    tick = edge_in && ((count_q & mask) == mask);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || (clk_en && clear)) begin
      count_q <= '0;
    end else if (clk_en && edge_in) begin
      count_q <= count_q + W'(1);
    end
  end

endmodule : ripple_prescaler
`default_nettype wire

// *** logic/sixteen_bit_timer_counter.sv ***
//
// Contract
// R1: 16-bit up-count in two software read/write bytes, wrapping from all ones to zero.
// R2: Every wrap to zero sets the sticky overflow flag at flag bit zero.
// R3: Overflow interrupt request only while overflow interrupt enable is set.
// R4: Clock source select clear counts once per instruction cycle, core clock over four.
// R5: Clock source select set counts rising external edges after the prescaler.
// R6: Counting only while timer on is set; clearing it holds the value.
// R7: A special event trigger input from compare units clears the count.
// R8: Crystal enable forces both oscillator pins to inputs; port reads return zero.
// R9: Sync control has no effect when the instruction clock is selected.
// R10: Counter mode needs a falling edge after enabling before rising edges count.
// R11: Counter clock comes from oscillator input pin if crystal enabled, else clock pin.
// R12: Sync clear in counter mode synchronises the prescaler output to phase clocks.
// R13: The prescaler is a ripple counter advanced by the selected clock input.
// R14: Synchronised counter mode stops counting during sleep.
// R15: Synchronised counter mode keeps the prescaler advancing during sleep.
// R16: Prescale select 00, 01, 10, 11 divides by 1, 2, 4, 8.
// R17: Sync set counts unsynchronised edges, runs in sleep, overflow can wake.
// R18: Trigger reset never sets overflow; a same-cycle software count write wins. Code sets the flag if a trigger meets an increment from all ones.
// R19: Count bytes are not cleared by any reset; only triggers clear them.
// R20: Writing either count byte clears the prescaler.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module sixteen_bit_timer_counter (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic sleep_mode,
  input wire logic special_event_trigger,
  input wire logic oscillator_input_pin_in,
  output logic oscillator_input_pin_out,
  output logic oscillator_input_pin_oe_n,
  input wire logic oscillator_output_clock_pin_in,
  output logic oscillator_output_clock_pin_out,
  output logic oscillator_output_clock_pin_oe_n,
  input wire logic [1:0] port_direction_bits,
  input wire logic [1:0] port_out_bits,
  output logic [1:0] port_read_bits,
  output logic overflow_irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int unsigned DIV_W = $clog2(timer_pkg::INSTR_DIV);

  logic [7:0] control_q, count_low_q, count_high_q;
  logic overflow_flag_q, overflow_interrupt_enable_q;
  logic [7:0] awaddr_q, wdata_q;
  logic wstrb0_q, aw_held_q, w_held_q;
  logic [DIV_W-1:0] instr_div_q;
  logic [1:0] pins_sync;
  logic clk_prev_q, armed_q, pending_q;

  logic timer_on, clock_source_select, sync_control, crystal_oscillator_enable;
  logic [1:0] prescale_select;
  logic instr_tick, ext_level, ext_rise, ext_fall, prescale_in, prescale_tick, count_inc, wrap;
  logic [15:0] count_now;
  logic wr_fire, wr_control, wr_low, wr_high, wr_flags, wr_enables, wr_hit, count_written;

  assign timer_on = control_q[timer_pkg::BIT_TIMER_ON];
  assign clock_source_select = control_q[timer_pkg::BIT_CLOCK_SOURCE];
  assign sync_control = control_q[timer_pkg::BIT_SYNC_CONTROL];
  assign crystal_oscillator_enable = control_q[timer_pkg::BIT_CRYSTAL_ENABLE];
  assign prescale_select = control_q[timer_pkg::BIT_PRESCALE_HI:timer_pkg::BIT_PRESCALE_LO];

  // Pins. Bit 0 is the clock-input pin, bit 1 the oscillator input pin.
  pin_sync #(.W(2)) u_pin_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .din({oscillator_input_pin_in, oscillator_output_clock_pin_in}),
    .dout(pins_sync)
  );

  // A set direction bit means input, so the enable follows it directly.
  always_comb begin
    oscillator_output_clock_pin_out = port_out_bits[0];
    oscillator_input_pin_out = port_out_bits[1];
    if (crystal_oscillator_enable) begin
      oscillator_output_clock_pin_oe_n = 1'b1; // see R8
      oscillator_input_pin_oe_n = 1'b1; // see R8
    end else begin
      oscillator_output_clock_pin_oe_n = port_direction_bits[0];
      oscillator_input_pin_oe_n = port_direction_bits[1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      port_read_bits <= 2'h0;
    end else if (clk_en) begin
      port_read_bits <= crystal_oscillator_enable ? 2'h0 : pins_sync; // see R8
    end
  end

  // Clock selection, edge detection and prescaler.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      instr_div_q <= '0;
    end else if (clk_en) begin
      instr_div_q <= instr_div_q + DIV_W'(1);
    end
  end

  // The core clock is gated in sleep, so the instruction clock stops there too.
  assign instr_tick = (instr_div_q == DIV_W'(timer_pkg::INSTR_DIV - 1)) && !sleep_mode; // see R4

  assign ext_level = crystal_oscillator_enable ? pins_sync[1] : pins_sync[0]; // see R11

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      clk_prev_q <= 1'b0;
    end else if (clk_en) begin
      clk_prev_q <= ext_level;
    end
  end

  assign ext_rise = ext_level && !clk_prev_q;
  assign ext_fall = !ext_level && clk_prev_q;

  // Leaving counter mode or stopping re-arms the wait for a falling edge.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      armed_q <= 1'b0;
    end else if (clk_en) begin
      if (!timer_on || !clock_source_select) begin
        armed_q <= 1'b0; // see R10
      end else if (ext_fall) begin
        armed_q <= 1'b1; // see R10
      end
    end
  end

  // The prescaler sees external edges even in sleep; only the sync stage stops.
  always_comb begin
    if (!timer_on) begin
      prescale_in = 1'b0; // see R6
    end else if (clock_source_select) begin
      prescale_in = ext_rise && armed_q; // see R5 R10 R13 R15
    end else begin
      prescale_in = instr_tick; // see R4
    end
  end

  ripple_prescaler #(.W(timer_pkg::PRESCALE_W)) u_prescaler (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .clear(count_written), // see R20
    .edge_in(prescale_in),
    .select(prescale_select), // see R16
    .tick(prescale_tick)
  );

  // In synchronised counter mode a prescaler tick waits for the next phase
  // clock, so a count can land up to three cycles after its edge.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pending_q <= 1'b0;
    end else if (clk_en) begin
      if (!timer_on || !clock_source_select || sync_control || sleep_mode) begin
        pending_q <= 1'b0; // see R14
      end else if (instr_tick) begin
        pending_q <= 1'b0;
      end else if (prescale_tick) begin
        pending_q <= 1'b1; // see R12
      end
    end
  end

  always_comb begin
    if (!timer_on) begin
      count_inc = 1'b0; // see R6
    end else if (!clock_source_select) begin
      count_inc = prescale_tick; // see R4 R9
    end else if (sync_control) begin
      count_inc = prescale_tick; // see R17
    end else begin
      count_inc = (pending_q || prescale_tick) && instr_tick && !sleep_mode; // see R12 R14
    end
  end

  assign count_now = {count_high_q, count_low_q};
  assign wrap = count_inc && !count_written && (count_now == timer_pkg::COUNT_ALL_ONES);

  // AXI4-Lite write path. Address and data are taken in either order.
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_control = 1'b0;
    wr_low = 1'b0;
    wr_high = 1'b0;
    wr_flags = 1'b0;
    wr_enables = 1'b0;
    wr_hit = 1'b1;
    if (awaddr_q == timer_pkg::ADDR_CONTROL) begin
      wr_control = wr_fire && wstrb0_q;
    end else if (awaddr_q == timer_pkg::ADDR_COUNT_LOW) begin
      wr_low = wr_fire && wstrb0_q;
    end else if (awaddr_q == timer_pkg::ADDR_COUNT_HIGH) begin
      wr_high = wr_fire && wstrb0_q;
    end else if (awaddr_q == timer_pkg::ADDR_FLAGS) begin
      wr_flags = wr_fire && wstrb0_q;
    end else if (awaddr_q == timer_pkg::ADDR_ENABLES) begin
      wr_enables = wr_fire && wstrb0_q;
    end else begin
      wr_hit = 1'b0;
    end
  end

  assign count_written = wr_low || wr_high;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= timer_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      control_q <= timer_pkg::CONTROL_RESET;
    end else if (clk_en && wr_control) begin
      control_q <= wdata_q & timer_pkg::CONTROL_WRITE_MASK;
    end
  end

  // The count has no reset, so it reads unknown until written or triggered.
  // A write updates only its own byte and suppresses that cycle's increment.
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      if (count_written) begin
        if (wr_low) begin
          count_low_q <= wdata_q; // see R1 R18
        end
        if (wr_high) begin
          count_high_q <= wdata_q; // see R1 R18
        end
      end else if (special_event_trigger) begin
        {count_high_q, count_low_q} <= timer_pkg::COUNT_ZERO; // see R7 R19
      end else if (count_inc) begin
        {count_high_q, count_low_q} <= count_now + 16'h0001; // see R1
      end
    end
  end

  // A wrap in the same cycle as a software clear still leaves the flag set.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      overflow_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (wrap) begin
        overflow_flag_q <= 1'b1; // see R2 R18
      end else if (wr_flags) begin
        overflow_flag_q <= wdata_q[timer_pkg::BIT_OVERFLOW];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      overflow_interrupt_enable_q <= 1'b0;
    end else if (clk_en && wr_enables) begin
      overflow_interrupt_enable_q <= wdata_q[timer_pkg::BIT_OVERFLOW];
    end
  end

  // This request is what wakes the processor from sleep in unsynchronised mode.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      overflow_irq <= 1'b0;
    end else if (clk_en) begin
      overflow_irq <= overflow_flag_q && overflow_interrupt_enable_q; // see R3 R17
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= timer_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= timer_pkg::RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        if (s_axi_araddr == timer_pkg::ADDR_CONTROL) begin
          s_axi_rdata[7:0] <= control_q;
        end else if (s_axi_araddr == timer_pkg::ADDR_COUNT_LOW) begin
          s_axi_rdata[7:0] <= count_low_q; // see R1
        end else if (s_axi_araddr == timer_pkg::ADDR_COUNT_HIGH) begin
          s_axi_rdata[7:0] <= count_high_q; // see R1
        end else if (s_axi_araddr == timer_pkg::ADDR_FLAGS) begin
          s_axi_rdata[timer_pkg::BIT_OVERFLOW] <= overflow_flag_q;
        end else if (s_axi_araddr == timer_pkg::ADDR_ENABLES) begin
          s_axi_rdata[timer_pkg::BIT_OVERFLOW] <= overflow_interrupt_enable_q;
        end else begin
          s_axi_rresp <= timer_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : sixteen_bit_timer_counter
`default_nettype wire

// *** bench/ext_clock_source.sv ***
`timescale 1ns/10ps
`default_nettype none
module ext_clock_source (
  input wire logic sys_clk,
  output logic clk_out
);
  // Idles high between bursts, so the first change inside a burst is a falling edge.
  initial clk_out = 1'b1;
  task automatic burst(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge sys_clk);
      clk_out <= 1'b0;
      repeat (half) @(posedge sys_clk);
      clk_out <= 1'b1;
    end
  endtask : burst
endmodule : ext_clock_source
`default_nettype wire

// *** bench/sixteen_bit_timer_counter_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module timer_bus_sva (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic overflow_irq,
  input wire logic oscillator_input_pin_oe_n,
  input wire logic oscillator_output_clock_pin_oe_n,
  input wire logic [1:0] port_direction_bits,
  input wire logic [1:0] port_read_bits,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  logic [5:0] ctl_q;
  logic en_q;
  logic wr_hs;
  logic mapped;
  assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign mapped = s_axi_awaddr inside {8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
  // The shadow assumes address and data are taken at one edge, as this bench offers them.
  // It moves one edge before the design's registers, so pin checks wait a cycle.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctl_q <= 6'h00;
      en_q <= 1'b0;
    end else if (wr_hs && s_axi_wstrb[0]) begin
      if (s_axi_awaddr == timer_pkg::ADDR_CONTROL) begin
        ctl_q <= s_axi_wdata[5:0];
      end
      if (s_axi_awaddr == timer_pkg::ADDR_ENABLES) begin
        en_q <= s_axi_wdata[0];
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  crystal_pins_a:
    assert property (ctl_q[3] && $past(ctl_q[3]) |->
      oscillator_input_pin_oe_n && oscillator_output_clock_pin_oe_n)
    else $error("oscillator pin driven with crystal enabled");
  port_zero_a:
    assert property (ctl_q[3] && $past(ctl_q[3], 2) |-> port_read_bits == 2'h0)
    else $error("port read not zero with crystal enabled");
  dir_pins_a:
    assert property (!ctl_q[3] && !$past(ctl_q[3]) |->
      {oscillator_input_pin_oe_n, oscillator_output_clock_pin_oe_n} == port_direction_bits)
    else $error("pin enables do not follow direction bits");
  irq_gate_a:
    assert property (!$past(en_q, 2) |-> !overflow_irq)
    else $error("overflow request while disabled");
  write_answer_a:
    assert property (wr_hs |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  write_refuse_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  bus_resp_a:
    assert property (wr_hs |-> ##2 s_axi_bresp ==
      ($past(mapped, 2) ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR))
    else $error("wrong write response code");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
endmodule : timer_bus_sva
bind sixteen_bit_timer_counter timer_bus_sva sva_u (
  .sys_clk, .sys_rst, .overflow_irq, .oscillator_input_pin_oe_n,
  .oscillator_output_clock_pin_oe_n, .port_direction_bits, .port_read_bits,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// *** bench/sixteen_bit_timer_counter_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module sixteen_bit_timer_counter_tb_top;
  typedef struct {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e; logic [1:0] r;} row_s;
  typedef struct {logic [7:0] ctl; logic slp; int half; logic [7:0] e;} edge_s;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic sleep_mode = 1'b0;
  logic special_event_trigger = 1'b0;
  logic trig_w = 1'b0;
  logic crystal = 1'b0;
  logic ext_clk;
  logic [1:0] port_direction_bits = 2'h0;
  logic [1:0] port_out_bits = 2'h2;
  logic [1:0] port_read_bits;
  logic overflow_irq;
  logic oscillator_input_pin_in, oscillator_input_pin_out, oscillator_input_pin_oe_n;
  logic oscillator_output_clock_pin_in, oscillator_output_clock_pin_out;
  logic oscillator_output_clock_pin_oe_n;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdat, held;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  row_s rows[8] = '{'{8'h10, 0, 8'h00, 8'h00, 2'h0}, '{8'h1c, 0, 8'h00, 8'h00, 2'h0},
    '{8'h20, 0, 8'h00, 8'h00, 2'h0}, '{8'h10, 1, 8'hfe, 8'h3e, 2'h0},
    '{8'h14, 1, 8'ha5, 8'ha5, 2'h0}, '{8'h18, 1, 8'h5a, 8'h5a, 2'h0},
    '{8'h24, 1, 8'h77, 8'h00, 2'h2}, '{8'h10, 1, 8'h00, 8'h00, 2'h0}};
  edge_s edges[6] = '{'{8'h07, 0, 8, 8'h08}, '{8'h13, 0, 8, 8'h04}, '{8'h27, 0, 5, 8'h02},
    '{8'h3b, 0, 8, 8'h01}, '{8'h03, 1, 8, 8'h00}, '{8'h0f, 1, 8, 8'h08}};
  always #12.5 sys_clk = ~sys_clk;
  // A released pin shows the clock source or a steady low, never a stale design level.
  assign oscillator_input_pin_in = oscillator_input_pin_oe_n ? (crystal & ext_clk)
    : oscillator_input_pin_out;
  assign oscillator_output_clock_pin_in = oscillator_output_clock_pin_oe_n ?
    (!crystal & ext_clk) : oscillator_output_clock_pin_out;
  sixteen_bit_timer_counter dut_u (.sys_clk, .sys_rst, .clk_en, .sleep_mode,
    .special_event_trigger, .oscillator_input_pin_in, .oscillator_input_pin_out,
    .oscillator_input_pin_oe_n, .oscillator_output_clock_pin_in,
    .oscillator_output_clock_pin_out, .oscillator_output_clock_pin_oe_n,
    .port_direction_bits, .port_out_bits, .port_read_bits, .overflow_irq, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ext_clock_source ext_u (.sys_clk(sys_clk), .clk_out(ext_clk));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      // Raised as the address is taken, the trigger meets the cycle the write lands.
      special_event_trigger <= trig_w && s_axi_awvalid && s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // The ceiling is about six times the length of the whole sequence.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk("pin enables", {oscillator_input_pin_oe_n, oscillator_output_clock_pin_oe_n}, 2'h0);
    chk("port read", port_read_bits, 2'h2);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
        chk("write response", resp, rows[i].r);
      end
      rd(rows[i].a);
      chk("read data", rdat, {24'h0, rows[i].e});
      chk("read response", resp, rows[i].r);
      if (i == 3) begin
        chk("crystal pins", {oscillator_input_pin_oe_n, oscillator_output_clock_pin_oe_n}, 2'h3);
        chk("crystal port read", port_read_bits, 2'h0);
      end
    end
    port_direction_bits <= 2'h3;
    foreach (edges[i]) begin
      crystal <= edges[i].ctl[3];
      sleep_mode <= edges[i].slp;
      wr(8'h14, 8'h00);
      wr(8'h18, 8'h00);
      wr(8'h10, edges[i].ctl);
      ext_u.burst(8, edges[i].half);
      repeat (12) @(posedge sys_clk);
      wr(8'h10, 8'h00);
      sleep_mode <= 1'b0;
      rd(8'h14);
      chk("edge count", rdat, {24'h0, edges[i].e});
    end
    wr(8'h14, 8'hff);
    wr(8'h18, 8'hff);
    wr(8'h20, 8'h01);
    wr(8'h10, 8'h01);
    repeat (12) @(posedge sys_clk);
    wr(8'h10, 8'h00);
    rd(8'h1c);
    chk("overflow flag", rdat, 32'h1);
    chk("overflow request", overflow_irq, 1'b1);
    rd(8'h18);
    chk("count high", rdat, 32'h0);
    rd(8'h14);
    chk("count low small", rdat < 32'h8, 1'b1);
    held = rdat;
    wr(8'h20, 8'h00);
    @(posedge sys_clk);
    chk("masked request", overflow_irq, 1'b0);
    rd(8'h14);
    chk("held count", rdat, held);
    wr(8'h1c, 8'h00);
    wr(8'h14, 8'h33);
    @(posedge sys_clk);
    special_event_trigger <= 1'b1;
    @(posedge sys_clk);
    special_event_trigger <= 1'b0;
    rd(8'h14);
    chk("trigger clear", rdat, 32'h0);
    rd(8'h1c);
    chk("trigger flag", rdat, 32'h0);
    trig_w = 1'b1;
    wr(8'h14, 8'h44);
    trig_w = 1'b0;
    rd(8'h14);
    chk("write over trigger", rdat, 32'h44);
    end_sim();
  end
endmodule : sixteen_bit_timer_counter_tb_top
`default_nettype wire
